// ### hfr_line_model.sv
// Remote station that sends framed data on the serial line
`timescale 1ns/100ps
module hfr_line_model (
  // Serial line
  output logic line_clk_out,
  output logic line_data_out
);
  logic [15:0] crc;
  int          ones;
  // Clock parked low between frames
  initial begin
    line_clk_out = 1'b0;
    line_data_out = 1'b1;
    ones = 0;
  end
  // One bit: data set while clock is low, taken at its rise
  task automatic bit_out(input logic b);
    line_data_out = b;
    #80 line_clk_out = 1'b1;
    #80 line_clk_out = 1'b0;
  endtask : bit_out
  // Byte LSB first; zero stuffed after five ones unless raw
  task automatic byte_out(input logic [7:0] b, input logic raw);
    for (int i = 0; i < 8; i++) begin
      bit_out(b[i]);
      ones = (b[i] && !raw) ? ones + 1 : 0;
      if (ones == 5) begin
        bit_out(1'b0);
        ones = 0;
      end
    end
  endtask : byte_out
  // Frame with optional opening flag; bad spoils the check sum
  task automatic frame(input logic [7:0] q[$], input logic open,
                       input logic bad);
    if (open) byte_out(8'h7E, 1'b1);
    crc = 16'hFFFF;
    foreach (q[k]) begin
      byte_out(q[k], 1'b0);
      crc = crc ^ {8'h00, q[k]};
      for (int j = 0; j < 8; j++)
        crc = crc[0] ? (crc >> 1) ^ 16'h8408 : crc >> 1;
    end
    crc = ~crc ^ {15'h0000, bad};
    byte_out(crc[7:0], 1'b0);
    byte_out(crc[15:8], 1'b0);
    byte_out(8'h7E, 1'b1);
    line_data_out = ~line_data_out; // Released line shows no stale level
  endtask : frame
endmodule : hfr_line_model

// ### hfr_pkg.sv
// Types shared by the frame receiver
package hfr_pkg;

  // Frame states
  typedef enum logic [2:0] {
    ST_HUNT,
    ST_ADDR_LO,
    ST_ADDR_HI,
    ST_RECV,
    ST_DROP,
    ST_CLOSE,
    ST_RELEASE
  } hfr_state_e;

  // Receive descriptor word
  typedef struct packed {
    logic        empty;
    logic        irq_en;
    logic [1:0]  rsvd_hi;
    logic        last;
    logic        too_long;
    logic        crc_err;
    logic        aborted;
    logic [7:0]  rsvd_lo;
    logic [15:0] len;
  } hfr_desc_s;

  // One decoded line event
  typedef struct packed {
    logic       flag;
    logic       abort;
    logic       byte_v;
    logic [7:0] data;
  } hfr_line_ev_s;

endpackage : hfr_pkg

// ### hfr_rx.sv
// HDLC frame receiver: line decode, address match, descriptors, APB regs
`timescale 1ns/100ps
`include "hfr_rx_regs.svh"

module hfr_rx #(
  parameter int NDESC   = 4,
  parameter int BUF_LEN = 8
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [9:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Serial line
  input  wire logic        line_clk_in,
  input  wire logic        line_data_in,
  // Interrupt
  output logic             irq_out
);

  localparam int DW = (NDESC > 1) ? $clog2(NDESC) : 1;
  localparam int PW = $clog2(BUF_LEN + 1);
  localparam int MW = $clog2(NDESC * BUF_LEN);

  // Software registers
  logic                     rx_enable;
  logic [15:0]              maxlen;
  logic [15:0]              addr_val [4];
  logic [15:0]              addr_mask;
  logic [7:0]               thresh;
  logic [`HFR_EV_W-1:0]     ev_mask;
  logic [`HFR_EV_W-1:0]     ev_stat;
  logic [31:0]              crc_check;
  logic [31:0]              crc_preset;
  logic [15:0]              discard_cnt;
  logic [15:0]              crc_err_cnt;
  logic [7:0]               frame_cnt;

  // Line side
  logic [2:0]               clk_sync;
  logic [1:0]               dat_sync;
  logic                     bit_edge;
  logic                     rx_bit;
  logic [7:0]               raw_hist;
  logic [2:0]               ones;
  logic [7:0]               shreg;
  logic [2:0]               nbits;
  hfr_pkg::hfr_line_ev_s    lev;

  // Frame side
  hfr_pkg::hfr_state_e      state;
  hfr_pkg::hfr_desc_s       desc [NDESC];
  logic [7:0]               rx_mem [NDESC * BUF_LEN];
  logic [DW-1:0]            cur;
  logic [DW-1:0]            next_cur;
  logic [PW-1:0]            pos;
  logic [15:0]              total;
  logic [15:0]              crc;
  logic [7:0]               addr_lo;
  logic [15:0]              rx_addr;
  logic [3:0]               hit;
  logic                     no_buf;
  logic                     too_long;
  logic                     aborted;
  logic                     crc_bad;
  logic [MW-1:0]            cur_base;
  logic [MW-1:0]            next_base;
  logic [MW-1:0]            wr_ptr;
  logic                     ev_buf_p;
  logic                     busy_p;
  logic                     inc_crc;
  logic                     frame_done;

  // Bus side
  logic [7:0]               idx;
  logic                     wr_en;
  logic                     desc_hit;
  logic                     mem_hit;
  logic [DW-1:0]            d_sel;
  logic [MW-1:0]            m_sel;
  logic [31:0]              rd_data;
  logic                     rd_ok;

  // Reflected CRC over one byte, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `HFR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Software view of a descriptor; reserved bits never stored
  function automatic hfr_pkg::hfr_desc_s sw_desc(input logic [31:0] w);
    hfr_pkg::hfr_desc_s d;
    d = hfr_pkg::hfr_desc_s'(w);
    d.rsvd_hi = 2'h0;
    d.rsvd_lo = 8'h00;
    return d;
  endfunction : sw_desc

  // Two-flop synchronisers; third clock flop only finds the edge
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      clk_sync <= 3'h0;
      dat_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], line_clk_in};
      dat_sync <= {dat_sync[0], line_data_in};
    end
  end

  assign bit_edge = clk_sync[1] & ~clk_sync[2];
  assign rx_bit   = dat_sync[1];

  // Flag hunt, zero removal, abort and byte assembly, low bit first
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      raw_hist <= 8'h00;
      ones     <= 3'h0;
      shreg    <= 8'h00;
      nbits    <= 3'h0;
      lev      <= '0;
    end else begin
      lev.flag   <= 1'b0;
      lev.abort  <= 1'b0;
      lev.byte_v <= 1'b0;
      if (bit_edge) begin
        raw_hist <= {rx_bit, raw_hist[7:1]};
        if (!rx_bit) begin
          ones <= 3'h0;
        end else if (ones != 3'h7) begin
          ones <= ones + 3'h1;
        end
        if ({rx_bit, raw_hist[7:1]} == `HFR_FLAG) begin
          lev.flag <= 1'b1;
          nbits    <= 3'h0;
        end else if (rx_bit && ones >= `HFR_ABORT_ONES) begin
          lev.abort <= 1'b1;
          nbits     <= 3'h0;
        end else if (rx_bit || ones != `HFR_STUFF_ONES) begin
          // Stuffed zero after five ones is skipped
          shreg <= {rx_bit, shreg[7:1]};
          nbits <= nbits + 3'h1;
          if (nbits == 3'h7) begin
            lev.byte_v <= 1'b1;
            lev.data   <= {rx_bit, shreg[7:1]};
          end
        end
      end
    end
  end

  // Masked address compare, one per address value
  assign rx_addr = {lev.data, addr_lo};
  for (genvar gi = 0; gi < 4; gi++) begin : g_match
    assign hit[gi] =
      (((rx_addr ^ addr_val[gi]) & addr_mask) == 16'h0000) ||
      ((addr_val[gi] == 16'hFFFF) && (rx_addr == 16'hFFFF));
  end

  // Buffer pointers; the table wraps after the last descriptor
  assign next_cur  = (int'(cur) == NDESC - 1) ? '0 : DW'(cur + 1'b1);
  assign cur_base  = MW'(int'(cur) * BUF_LEN);
  assign next_base = MW'(int'(next_cur) * BUF_LEN);
  assign wr_ptr    = cur_base + MW'(pos);

  // Frame sequencing, buffer storage and descriptor ownership
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state      <= hfr_pkg::ST_HUNT;
      cur        <= '0;
      pos        <= '0;
      total      <= 16'h0000;
      crc        <= 16'h0000;
      addr_lo    <= 8'h00;
      no_buf     <= 1'b0;
      too_long   <= 1'b0;
      aborted    <= 1'b0;
      crc_bad    <= 1'b0;
      ev_buf_p   <= 1'b0;
      busy_p     <= 1'b0;
      inc_crc    <= 1'b0;
      frame_done <= 1'b0;
      for (int i = 0; i < NDESC; i++) begin
        desc[i] <= '0;
      end
    end else begin
      ev_buf_p   <= 1'b0;
      busy_p     <= 1'b0;
      inc_crc    <= 1'b0;
      frame_done <= 1'b0;
      // Every flag restarts the check from the preset
      if (lev.flag) begin
        crc <= crc_preset[15:0];
      end else if (lev.byte_v) begin
        crc <= crc_byte(crc, lev.data);
      end
      case (state)
        hfr_pkg::ST_HUNT: begin
          if (lev.flag) begin
            state <= hfr_pkg::ST_ADDR_LO;
          end
        end
        hfr_pkg::ST_ADDR_LO: begin
          if (lev.abort) begin
            state <= hfr_pkg::ST_HUNT;
          end else if (lev.byte_v) begin
            // Early look at the descriptor; nothing owned until match
            addr_lo  <= lev.data;
            no_buf   <= ~desc[cur].empty;
            too_long <= 1'b0;
            pos      <= PW'(1);
            total    <= 16'h0001;
            if (desc[cur].empty) begin
              rx_mem[cur_base] <= lev.data;
            end
            state <= hfr_pkg::ST_ADDR_HI;
          end
        end
        hfr_pkg::ST_ADDR_HI: begin
          if (lev.flag) begin
            state <= hfr_pkg::ST_ADDR_LO;
          end else if (lev.abort) begin
            state <= hfr_pkg::ST_HUNT;
          end else if (lev.byte_v) begin
            if (hit == 4'h0) begin
              pos   <= '0;
              state <= hfr_pkg::ST_DROP;
            end else if (no_buf || !desc[cur].empty) begin
              busy_p <= 1'b1;
              pos    <= '0;
              state  <= hfr_pkg::ST_DROP;
            end else begin
              rx_mem[wr_ptr] <= lev.data;
              pos            <= pos + PW'(1);
              total          <= 16'h0002;
              state          <= hfr_pkg::ST_RECV;
            end
          end
        end
        hfr_pkg::ST_RECV: begin
          if (lev.flag || lev.abort) begin
            // Residue taken before the flag reloads the preset
            crc_bad <= (crc != crc_check[15:0]);
            aborted <= lev.abort;
            state   <= hfr_pkg::ST_CLOSE;
          end else if (lev.byte_v) begin
            total <= total + 16'h0001;
            if (too_long || total >= maxlen) begin
              // Bytes past the maximum are counted, not stored
              too_long <= 1'b1;
            end else if (int'(pos) == BUF_LEN) begin
              desc[cur].empty <= 1'b0;
              desc[cur].len   <= 16'(BUF_LEN);
              ev_buf_p        <= desc[cur].irq_en;
              cur             <= next_cur;
              if (desc[next_cur].empty) begin
                rx_mem[next_base] <= lev.data;
                pos               <= PW'(1);
              end else begin
                busy_p <= 1'b1;
                state  <= hfr_pkg::ST_DROP;
              end
            end else begin
              rx_mem[wr_ptr] <= lev.data;
              pos            <= pos + PW'(1);
            end
          end
        end
        hfr_pkg::ST_DROP: begin
          if (lev.flag) begin
            state <= hfr_pkg::ST_ADDR_LO;
          end else if (lev.abort) begin
            state <= hfr_pkg::ST_HUNT;
          end
        end
        hfr_pkg::ST_CLOSE: begin
          // Status and last first; empty cleared one cycle later
          desc[cur].last     <= 1'b1;
          desc[cur].too_long <= too_long;
          desc[cur].crc_err  <= crc_bad & ~aborted;
          desc[cur].aborted  <= aborted;
          desc[cur].len      <= total;
          inc_crc            <= crc_bad & ~aborted;
          state              <= hfr_pkg::ST_RELEASE;
        end
        hfr_pkg::ST_RELEASE: begin
          desc[cur].empty <= 1'b0;
          cur             <= next_cur;
          pos             <= '0;
          frame_done      <= ~aborted;
          // The closing flag already opened the next frame
          state <= aborted ? hfr_pkg::ST_HUNT : hfr_pkg::ST_ADDR_LO;
        end
        default: begin
          state <= hfr_pkg::ST_HUNT;
        end
      endcase
      if (!rx_enable) begin
        state <= hfr_pkg::ST_HUNT;
      end
      // Software arms descriptors; its write also replaces armed ones and wins over the frame logic
      if (wr_en && desc_hit) begin
        desc[d_sel] <= sw_desc(pwdata_in);
      end
    end
  end

  // Control and parameter registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rx_enable  <= 1'b0;
      maxlen     <= `HFR_RST_MAXLEN;
      addr_mask  <= `HFR_RST_ADDR_MASK;
      thresh     <= 8'h00;
      ev_mask    <= '0;
      crc_check  <= `HFR_RST_CRC_CHECK;
      crc_preset <= `HFR_RST_CRC_PRESET;
      for (int i = 0; i < 4; i++) begin
        addr_val[i] <= `HFR_RST_ADDR;
      end
    end else if (wr_en) begin
      case (idx)
        `HFR_IDX_CTRL:       rx_enable  <= pwdata_in[0];
        `HFR_IDX_MAXLEN:     maxlen     <= pwdata_in[15:0];
        `HFR_IDX_ADDR0:      addr_val[0] <= pwdata_in[15:0];
        `HFR_IDX_ADDR1:      addr_val[1] <= pwdata_in[15:0];
        `HFR_IDX_ADDR2:      addr_val[2] <= pwdata_in[15:0];
        `HFR_IDX_ADDR3:      addr_val[3] <= pwdata_in[15:0];
        `HFR_IDX_ADDR_MASK:  addr_mask  <= pwdata_in[15:0];
        `HFR_IDX_THRESH:     thresh     <= pwdata_in[7:0];
        `HFR_IDX_EV_MASK:    ev_mask    <= pwdata_in[`HFR_EV_W-1:0];
        `HFR_IDX_CRC_CHECK:  crc_check  <= pwdata_in;
        `HFR_IDX_CRC_PRESET: crc_preset <= pwdata_in;
        default: begin
        end
      endcase
    end
  end

  // Error counters; a software write and a count add together
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      discard_cnt <= 16'h0000;
      crc_err_cnt <= 16'h0000;
    end else begin
      if (wr_en && idx == `HFR_IDX_DISCARD) begin
        discard_cnt <= pwdata_in[15:0] + {15'h0000, busy_p};
      end else begin
        discard_cnt <= discard_cnt + {15'h0000, busy_p};
      end
      if (wr_en && idx == `HFR_IDX_CRC_ERR) begin
        crc_err_cnt <= pwdata_in[15:0] + {15'h0000, inc_crc};
      end else begin
        crc_err_cnt <= crc_err_cnt + {15'h0000, inc_crc};
      end
    end
  end

  // Sticky events with threshold; a new event beats its own clear
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ev_stat   <= '0;
      frame_cnt <= 8'h00;
      irq_out   <= 1'b0;
    end else begin
      logic [`HFR_EV_W-1:0] set_v;
      logic [`HFR_EV_W-1:0] clr_v;
      set_v = '0;
      clr_v = (wr_en && idx == `HFR_IDX_EVENT) ?
              pwdata_in[`HFR_EV_W-1:0] : '0;
      set_v[`HFR_EV_BUFFER] = ev_buf_p;
      set_v[`HFR_EV_BUSY]   = busy_p;
      if (frame_done) begin
        if (thresh == 8'h00 || frame_cnt + 8'h01 >= thresh) begin
          set_v[`HFR_EV_FRAME] = 1'b1;
          frame_cnt            <= 8'h00;
        end else begin
          frame_cnt <= frame_cnt + 8'h01;
        end
      end
      ev_stat <= (ev_stat & ~clr_v) | set_v;
      irq_out <= |(ev_stat & ev_mask);
    end
  end

  // APB decode; a transfer completes when pready is seen high
  assign idx      = paddr_in[9:2];
  assign wr_en    = psel_in & penable_in & pready_out & pwrite_in;
  assign desc_hit = (idx >= `HFR_IDX_DESC0) &&
                    (int'(idx) < int'(`HFR_IDX_DESC0) + NDESC);
  assign mem_hit  = (idx >= `HFR_IDX_MEM0) &&
                    (int'(idx) < int'(`HFR_IDX_MEM0) + NDESC * BUF_LEN);
  assign d_sel    = DW'(idx - `HFR_IDX_DESC0);
  assign m_sel    = MW'(idx - `HFR_IDX_MEM0);

  // Read mux; unmapped indexes answer with an error
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (desc_hit) begin
      rd_data = desc[d_sel];
    end else if (mem_hit) begin
      rd_data = {24'h000000, rx_mem[m_sel]};
    end else begin
      case (idx)
        `HFR_IDX_CTRL:       rd_data = {31'h00000000, rx_enable};
        `HFR_IDX_MAXLEN:     rd_data = {16'h0000, maxlen};
        `HFR_IDX_ADDR0:      rd_data = {16'h0000, addr_val[0]};
        `HFR_IDX_ADDR1:      rd_data = {16'h0000, addr_val[1]};
        `HFR_IDX_ADDR2:      rd_data = {16'h0000, addr_val[2]};
        `HFR_IDX_ADDR3:      rd_data = {16'h0000, addr_val[3]};
        `HFR_IDX_ADDR_MASK:  rd_data = {16'h0000, addr_mask};
        `HFR_IDX_THRESH:     rd_data = {24'h000000, thresh};
        `HFR_IDX_EVENT:      rd_data = {29'h00000000, ev_stat};
        `HFR_IDX_EV_MASK:    rd_data = {29'h00000000, ev_mask};
        `HFR_IDX_STATUS:     rd_data = {16'h0000, frame_cnt, 5'h00,
                                        state};
        `HFR_IDX_RESERVED:   rd_data = 32'h00000000;
        `HFR_IDX_CRC_CHECK:  rd_data = crc_check;
        `HFR_IDX_CRC_PRESET: rd_data = crc_preset;
        `HFR_IDX_DISCARD:    rd_data = {16'h0000, discard_cnt};
        `HFR_IDX_CRC_ERR:    rd_data = {16'h0000, crc_err_cnt};
        default:             rd_ok   = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~rd_ok;
      if (psel_in && penable_in && !pready_out) begin
        prdata_out <= pwrite_in ? 32'h00000000 : rd_data;
      end
    end
  end

endmodule : hfr_rx

// ### hfr_rx_regs.svh
// Register indexes, reset values and line constants of the frame receiver
`ifndef HFR_RX_REGS_SVH
`define HFR_RX_REGS_SVH

// Word indexes; byte address is four times the index
`define HFR_IDX_CTRL       8'h00
`define HFR_IDX_MAXLEN     8'h01
`define HFR_IDX_ADDR0      8'h02
`define HFR_IDX_ADDR1      8'h03
`define HFR_IDX_ADDR2      8'h04
`define HFR_IDX_ADDR3      8'h05
`define HFR_IDX_ADDR_MASK  8'h06
`define HFR_IDX_THRESH     8'h07
`define HFR_IDX_EVENT      8'h08
`define HFR_IDX_EV_MASK    8'h09
`define HFR_IDX_STATUS     8'h0A
`define HFR_IDX_DESC0      8'h10
`define HFR_IDX_RESERVED   8'h30
`define HFR_IDX_CRC_CHECK  8'h34
`define HFR_IDX_CRC_PRESET 8'h38
`define HFR_IDX_DISCARD    8'h3C
`define HFR_IDX_CRC_ERR    8'h3E
`define HFR_IDX_MEM0       8'h40

// Reset values
`define HFR_RST_MAXLEN     16'h0100
`define HFR_RST_ADDR       16'h0000
`define HFR_RST_ADDR_MASK  16'hFFFF
`define HFR_RST_CRC_CHECK  32'h0000F0B8
`define HFR_RST_CRC_PRESET 32'h0000FFFF

// Event bit positions
`define HFR_EV_FRAME       0
`define HFR_EV_BUFFER      1
`define HFR_EV_BUSY        2
`define HFR_EV_W           3

// Line constants
`define HFR_FLAG           8'h7E
`define HFR_CRC_POLY       16'h8408
`define HFR_STUFF_ONES     3'h5
`define HFR_ABORT_ONES     3'h6

`endif

// ### hfr_rx_sva.sv
// Checker of the receiver's register port and interrupt pin
`timescale 1ns/100ps
module hfr_rx_sva (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  // Register bus
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [9:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Interrupt
  input wire logic        irq_out
);
  logic       rd_done;
  logic [7:0] idx;
  // Completed reads and the word they address
  assign rd_done = pready_out && !pwrite_in;
  assign idx = paddr_in[9:2];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held past one cycle");
  AST_READY_TIME: assert property (psel_in && penable_in &&
    !$past(penable_in) |=> pready_out)
    else $error("ready not one cycle into access");
  AST_READY_CAUSE: assert property (pready_out |->
    $past(psel_in && penable_in))
    else $error("ready without access phase");
  AST_ERR_ZERO: assert property (pslverr_out |->
    pready_out && prdata_out == 32'h00000000)
    else $error("error without ready or with data");
  AST_RSVD_ZERO: assert property (rd_done && idx == 8'h30 |->
    prdata_out == 32'h00000000 && !pslverr_out)
    else $error("reserved word not zero");
  AST_CNT_WIDTH: assert property (rd_done && idx >= 8'h3C &&
    idx <= 8'h3E |-> prdata_out[31:16] == 16'h0000)
    else $error("counter wider than a half word");
  AST_DESC_RSVD: assert property (rd_done && idx[7:2] == 6'h04
    |-> prdata_out[29:28] == 2'h0 && prdata_out[23:16] == 8'h00)
    else $error("descriptor reserved bits set");
  AST_BUF_BYTE: assert property (rd_done && idx[7:6] == 2'h1
    |-> prdata_out[31:8] == 24'h000000)
    else $error("buffer byte wider than eight bits");
  AST_IRQ_DROP: assert property ($fell(irq_out) |->
    $past(psel_in && penable_in && pwrite_in) ||
    $past(psel_in && penable_in && pwrite_in, 2))
    else $error("interrupt fell without a write");
endmodule : hfr_rx_sva
bind hfr_rx hfr_rx_sva hfr_rx_sva_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_out(irq_out)
);

// ### hfr_rx_test.sv
// Self-checking bench for the HDLC frame receiver
`timescale 1ns/100ps
`include "hfr_rx_regs.svh"
module hfr_rx_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwd = 32'h00000000, prd, rdata;
  logic        prdy, perr, irq, lclk, ldata, err;
  int          fails = 0, checks = 0, cyc = 0;
  logic [7:0]  fa[$] = '{8'h34, 8'h12, 8'hA1, 8'hA2, 8'hA3, 8'hA4};
  logic [7:0]  fb[$] = '{8'hFF, 8'hFF, 8'h01, 8'h02, 8'h03, 8'h04,
                         8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
  logic [7:0]  fc[$] = '{8'h55, 8'h55, 8'h01};
  hfr_rx #(.NDESC(4), .BUF_LEN(8)) hfr_rx_inst (
    .clock_in(clk), .rst_n_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .line_clk_in(lclk), .line_data_in(ldata), .irq_out(irq));
  hfr_line_model hfr_line_model_inst (.line_clk_out(lclk),
    .line_data_out(ldata));
  // 125 MHz clock
  always #4 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No wait limit here; only the bench timeout ends a hang
    do @(posedge clk); while (prdy !== 1'b1);
    rdata = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h00000000);
    chk($sformatf("word %h", i), e, rdata);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (30) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`HFR_IDX_MAXLEN, 32'h00000100);
    rd(`HFR_IDX_ADDR_MASK, 32'h0000FFFF);
    rd(`HFR_IDX_CRC_CHECK, 32'h0000F0B8);
    rd(`HFR_IDX_CRC_PRESET, 32'h0000FFFF);
    rd(`HFR_IDX_RESERVED, 32'h00000000);
    rd(8'h0B, 32'h00000000);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(16 + i), 32'hC0000000);
    apb(1'b1, `HFR_IDX_ADDR0, 32'h00001234);
    apb(1'b1, `HFR_IDX_ADDR3, 32'h0000FFFF);
    apb(1'b1, `HFR_IDX_EV_MASK, 32'h00000003);
    apb(1'b1, `HFR_IDX_CTRL, 32'h00000001);
    hfr_line_model_inst.byte_out(8'h55, 1'b0);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b0);
    hfr_line_model_inst.frame(fb, 1'b0, 1'b0);
    irq_is(1'b1);
    rd(`HFR_IDX_DESC0, 32'h48000008);
    rd(`HFR_IDX_MEM0, 32'h00000034);
    rd(`HFR_IDX_DESC0 + 8'h01, 32'h40000008);
    rd(`HFR_IDX_DESC0 + 8'h02, 32'h4800000D);
    rd(`HFR_IDX_EVENT, 32'h00000003);
    apb(1'b1, `HFR_IDX_EV_MASK, 32'h00000000);
    irq_is(1'b0);
    apb(1'b1, `HFR_IDX_EV_MASK, 32'h00000003);
    irq_is(1'b1);
    apb(1'b1, `HFR_IDX_EVENT, 32'h00000007);
    irq_is(1'b0);
    hfr_line_model_inst.frame(fc, 1'b1, 1'b0);
    irq_is(1'b0);
    rd(`HFR_IDX_DESC0 + 8'h03, 32'hC0000000);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b1);
    irq_is(1'b1);
    rd(`HFR_IDX_DESC0 + 8'h03, 32'h4A000008);
    rd(`HFR_IDX_CRC_ERR, 32'h00000001);
    apb(1'b1, `HFR_IDX_EVENT, 32'h00000007);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b0);
    irq_is(1'b0);
    rd(`HFR_IDX_DISCARD, 32'h00000001);
    rd(`HFR_IDX_EVENT, 32'h00000004);
    apb(1'b1, `HFR_IDX_THRESH, 32'h00000002);
    apb(1'b1, `HFR_IDX_EVENT, 32'h00000007);
    for (int i = 0; i < 2; i++) apb(1'b1, 8'(16 + i), 32'hC0000000);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b0);
    irq_is(1'b0);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b0);
    irq_is(1'b1);
    // Short maximum: whole length kept, too-long flag set
    apb(1'b1, `HFR_IDX_MAXLEN, 32'h00000004);
    apb(1'b1, 8'(18), 32'hC0000000);
    hfr_line_model_inst.frame(fa, 1'b1, 1'b0);
    rd(`HFR_IDX_DESC0 + 8'h02, 32'h4C000008);
    final_report();
  end
endmodule : hfr_rx_test
